// ==== hdl/tsp_pkg.sv ====
// Notes on behaviour
// - While reset is low every register of the port goes back to its default value.
// - The interrupt output is active low and shows pen touch, data available or both.
// - Transfers use clock polarity 0 and phase 0, with the serial clock idling low.
// - Serial output changes on falling edges and serial input is sampled on rising edges.
// - A control-byte cycle completes after exactly 8 serial clocks.
// - A register access cycle completes after exactly 24 serial clocks.
// - Chip select may stay low over several back-to-back cycles, each with its own address.
// - Chip select is the slave select, serial input is master-out, serial output is master-in.
// - When chip select goes high the serial output is released to high impedance.
package tsp_pkg;

  // ==========================================================================
  // Frame geometry
  localparam int          CMD_W        = 8;
  localparam int          DATA_W       = 16;
  localparam int          ADDR_W       = 4;
  localparam int          CNT_W        = 5;
  localparam logic [4:0]  LAST_CMD_BIT = 5'h07;   // 8th clock ends the command byte
  localparam logic [4:0]  LAST_ACC_BIT = 5'h17;   // 24th clock ends an access
  localparam logic [4:0]  CNT_ONE      = 5'h01;
  localparam logic [4:0]  CNT_ZERO     = 5'h00;

  // ==========================================================================
  // Command byte fields
  localparam int          CMD_CTRL_BIT = 7;       // 1: control byte, 0: register access
  localparam int          CMD_ADDR_MSB = 6;
  localparam int          CMD_ADDR_LSB = 3;
  localparam int          CMD_READ_BIT = 2;       // 1: read, 0: write

  // ==========================================================================
  // Interrupt source selection
  localparam logic [1:0]  IRQ_SEL_PEN  = 2'h0;
  localparam logic [1:0]  IRQ_SEL_DATA = 2'h1;
  localparam logic [1:0]  IRQ_SEL_BOTH = 2'h2;

  // ==========================================================================
  // Reset values
  localparam logic [15:0] DATA_RST     = 16'h0000;
  localparam logic [7:0]  CMD_RST      = 8'h00;

endpackage : tsp_pkg

// ==== hdl/tsp_spi_port.sv ====
module tsp_spi_port (
  input  wire logic        clk,
  input  wire logic        resetn,
  // Link pins
  input  wire logic        sclk,
  input  wire logic        cs_n,
  input  wire logic        serial_in_pin,
  output logic             serial_out_pin,
  output logic             serial_out_oe,
  output logic             touch_data_irq_out,
  // Device side, clk domain
  input  wire logic [1:0]  irq_sel,
  input  wire logic        pen_touch_flag,
  input  wire logic        data_avail,
  input  wire logic        mirror_wr,
  input  wire logic [3:0]  mirror_addr,
  input  wire logic [15:0] mirror_data,
  output logic             mirror_ready,
  output logic             cmd_valid,
  output logic [7:0]       cmd_byte,
  output logic             wr_valid,
  output logic [3:0]       wr_addr,
  output logic [15:0]      wr_data
);

  // ==========================================================================
  // State types
  typedef struct packed {
    logic [tsp_pkg::CNT_W-1:0]  cnt;     // Rising edges seen in current cycle
    logic [tsp_pkg::DATA_W-1:0] sh;      // Input shifter
    logic [tsp_pkg::CMD_W-1:0]  cmd;     // Command byte of current access
    logic [tsp_pkg::DATA_W-1:0] out_sh;  // Read data shifter
  } tsp_link_t;

  typedef struct packed {
    logic                       tog;     // Flips once per completed cycle
    logic                       ctrl;
    logic [tsp_pkg::CMD_W-1:0]  cmd;
    logic [tsp_pkg::DATA_W-1:0] data;
  } tsp_hand_t;

  typedef struct packed {
    logic oe;
    logic dout;
  } tsp_drv_t;

  typedef struct packed {
    logic [15:0][tsp_pkg::DATA_W-1:0] mirror;  // Readback words
    logic                       tog_s1;
    logic                       tog_s2;
    logic                       tog_s3;
    logic                       cs_s1;
    logic                       cs_s2;
    logic                       mirror_ready;
    logic                       cmd_valid;
    logic [tsp_pkg::CMD_W-1:0]  cmd_byte;
    logic                       wr_valid;
    logic [tsp_pkg::ADDR_W-1:0] wr_addr;
    logic [tsp_pkg::DATA_W-1:0] wr_data;
    logic                       irq_n;
  } tsp_sys_t;

  tsp_link_t lk, next_lk;
  tsp_hand_t hd, next_hd;
  tsp_drv_t  dv, next_dv;
  tsp_sys_t  sy, next_sy;

  // Frame state is cleared by chip select high, so a cut cycle leaves no trace
  logic link_rst_n;
  assign link_rst_n = resetn & ~cs_n;

  // ==========================================================================
  // Link domain, rising edge: sample input, count, complete cycles
  always_comb begin
    logic [tsp_pkg::CMD_W-1:0] cmd_in;
    cmd_in  = {lk.sh[tsp_pkg::CMD_W-2:0], serial_in_pin};
    next_lk = lk;
    next_hd = hd;
    next_lk.sh = {lk.sh[tsp_pkg::DATA_W-2:0], serial_in_pin};
    if (lk.cnt == tsp_pkg::LAST_CMD_BIT) begin
      if (cmd_in[tsp_pkg::CMD_CTRL_BIT]) begin
        next_hd.tog  = ~hd.tog;
        next_hd.ctrl = 1'b1;
        next_hd.cmd  = cmd_in;
        next_lk.cnt  = tsp_pkg::CNT_ZERO;
      end else begin
        next_lk.cmd    = cmd_in;
        // Mirror is frozen while a frame is open, so this read is stable
        next_lk.out_sh = sy.mirror[cmd_in[tsp_pkg::CMD_ADDR_MSB:tsp_pkg::CMD_ADDR_LSB]];
        next_lk.cnt    = lk.cnt + tsp_pkg::CNT_ONE;
      end
    end else if (lk.cnt == tsp_pkg::LAST_ACC_BIT) begin
      next_hd.tog  = ~hd.tog;
      next_hd.ctrl = 1'b0;
      next_hd.cmd  = lk.cmd;
      next_hd.data = {lk.sh[tsp_pkg::DATA_W-2:0], serial_in_pin};
      next_lk.cnt  = tsp_pkg::CNT_ZERO;
    end else begin
      next_lk.cnt = lk.cnt + tsp_pkg::CNT_ONE;
      if (lk.cnt > tsp_pkg::LAST_CMD_BIT) begin
        next_lk.out_sh = {lk.out_sh[tsp_pkg::DATA_W-2:0], 1'b0};
      end
    end
  end

  // Frame registers, wiped on chip select high or system reset
  always_ff @(posedge sclk or negedge link_rst_n) begin
    if (!link_rst_n) begin
      lk <= '{cnt: tsp_pkg::CNT_ZERO, sh: tsp_pkg::DATA_RST, cmd: tsp_pkg::CMD_RST,
              out_sh: tsp_pkg::DATA_RST};
    end else begin
      lk <= next_lk;
    end
  end

  // Hand-off word must survive chip select rising, hence system reset only
  always_ff @(posedge sclk or negedge resetn) begin
    if (!resetn) begin
      hd <= '{tog: 1'b0, ctrl: 1'b0, cmd: tsp_pkg::CMD_RST, data: tsp_pkg::DATA_RST};
    end else begin
      hd <= next_hd;
    end
  end

  // ==========================================================================
  // Link domain, falling edge: drive master-in line
  always_comb begin
    next_dv    = dv;
    next_dv.oe = 1'b1;
    if (lk.cnt > tsp_pkg::LAST_CMD_BIT && lk.cmd[tsp_pkg::CMD_READ_BIT]) begin
      next_dv.dout = lk.out_sh[tsp_pkg::DATA_W-1];
    end else begin
      next_dv.dout = 1'b0;
    end
  end

  // Enable drops asynchronously with chip select so the line floats at once
  always_ff @(negedge sclk or negedge link_rst_n) begin
    if (!link_rst_n) begin
      dv <= '{oe: 1'b0, dout: 1'b0};
    end else begin
      dv <= next_dv;
    end
  end

  assign serial_out_pin = dv.dout;
  assign serial_out_oe  = dv.oe;

  // ==========================================================================
  // System domain: toggle crossing, mirror, interrupt
  always_comb begin
    next_sy           = sy;
    next_sy.tog_s1    = hd.tog;
    next_sy.tog_s2    = sy.tog_s1;
    next_sy.tog_s3    = sy.tog_s2;
    next_sy.cs_s1     = cs_n;
    next_sy.cs_s2     = sy.cs_s1;
    next_sy.cmd_valid = 1'b0;
    next_sy.wr_valid  = 1'b0;
    // Only complete cycles arrive here; a cut one never flips the toggle
    if (sy.tog_s2 != sy.tog_s3) begin
      if (hd.ctrl) begin
        next_sy.cmd_valid = 1'b1;
        next_sy.cmd_byte  = hd.cmd;
      end else if (!hd.cmd[tsp_pkg::CMD_READ_BIT]) begin
        next_sy.wr_valid = 1'b1;
        next_sy.wr_addr  = hd.cmd[tsp_pkg::CMD_ADDR_MSB:tsp_pkg::CMD_ADDR_LSB];
        next_sy.wr_data  = hd.data;
      end
    end
    // Readback words only change while the link is idle
    next_sy.mirror_ready = sy.cs_s2;
    if (mirror_wr && sy.mirror_ready) begin
      next_sy.mirror[mirror_addr] = mirror_data;
    end
    case (irq_sel)
      tsp_pkg::IRQ_SEL_PEN:  next_sy.irq_n = ~pen_touch_flag;
      tsp_pkg::IRQ_SEL_DATA: next_sy.irq_n = ~data_avail;
      tsp_pkg::IRQ_SEL_BOTH: next_sy.irq_n = ~(pen_touch_flag | data_avail);
      default:               next_sy.irq_n = 1'b1;
    endcase
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      sy <= '{mirror: '0, tog_s1: 1'b0, tog_s2: 1'b0, tog_s3: 1'b0, cs_s1: 1'b1,
              cs_s2: 1'b1, mirror_ready: 1'b0, cmd_valid: 1'b0, cmd_byte: tsp_pkg::CMD_RST,
              wr_valid: 1'b0, wr_addr: '0, wr_data: tsp_pkg::DATA_RST, irq_n: 1'b1};
    end else begin
      sy <= next_sy;
    end
  end

  assign touch_data_irq_out = sy.irq_n;
  assign mirror_ready       = sy.mirror_ready;
  assign cmd_valid          = sy.cmd_valid;
  assign cmd_byte           = sy.cmd_byte;
  assign wr_valid           = sy.wr_valid;
  assign wr_addr            = sy.wr_addr;
  assign wr_data            = sy.wr_data;

endmodule : tsp_spi_port

// ==== test/tsp_spi_port_props.sv ====
module tsp_spi_port_props (
  input wire logic        clk,
  input wire logic        resetn,
  input wire logic        sclk,
  input wire logic        cs_n,
  input wire logic        serial_out_pin,
  input wire logic        serial_out_oe,
  input wire logic        touch_data_irq_out,
  input wire logic [1:0]  irq_sel,
  input wire logic        pen_touch_flag,
  input wire logic        mirror_ready,
  input wire logic        cmd_valid,
  input wire logic [7:0]  cmd_byte,
  input wire logic        wr_valid,
  input wire logic [15:0] wr_data
);
  timeunit 1ns;
  timeprecision 1ps;
  // ========
  // Checks on the system clock
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!resetn);
  // Select low long enough to pass the synchroniser
  sequence seq_busy;
    !cs_n [*5];
  endsequence
  chk_reset_vals: assert property ($rose(resetn) |->
    touch_data_irq_out && !cmd_valid && !wr_valid && !mirror_ready)
    else $error("bad value after reset");
  chk_irq_pen: assert property ($past(resetn) && $past(irq_sel) == 2'h0 |->
    touch_data_irq_out == !$past(pen_touch_flag))
    else $error("irq does not follow pen flag");
  chk_out_edge: assert property (!cs_n && $changed(serial_out_pin) |-> !sclk)
    else $error("serial out moved while clock high");
  chk_oe_rise: assert property ($rose(serial_out_oe) |-> !sclk && !cs_n)
    else $error("output enable rose off a falling edge");
  chk_cmd_ctrl: assert property (cmd_valid |-> cmd_byte[7] ##1 !cmd_valid)
    else $error("bad control byte pulse");
  chk_wr_hold: assert property (wr_valid |=> !wr_valid && $stable(wr_data))
    else $error("write pulse too long or data moved");
  chk_ready_busy: assert property (seq_busy |-> !mirror_ready)
    else $error("mirror ready during a frame");
  chk_oe_release: assert property (cs_n |-> !serial_out_oe)
    else $error("output enabled while deselected");
endmodule : tsp_spi_port_props

// ==== test/tsp_host.sv ====
module tsp_host (
  output logic           sclk,
  output logic           cs_n,
  output logic           serial_in_pin,
  input  wire logic      serial_out_pin
);
  timeunit 1ns;
  timeprecision 1ps;
  // ========
  // Idle bus: clock low, deselected
  initial begin
    sclk = 1'b0;
    cs_n = 1'b1;
    serial_in_pin = 1'b0;
  end
  // One cycle of n clocks at 30 ns, MSB first; keep leaves select low
  task automatic xfer(input logic [23:0] d, input int n, input bit keep, output logic [23:0] q);
    cs_n = 1'b0;
    // Half-ns offset keeps link edges off the system clock edges when the call starts on a whole ns
    #30.5;
    for (int i = n - 1; i >= 0; i--) begin
      serial_in_pin = d[i];
      #15 sclk = 1'b1;
      q = {q[22:0], serial_out_pin};
      #15 sclk = 1'b0;
    end
    #30;
    cs_n = keep ? 1'b0 : 1'b1;
    serial_in_pin = ~serial_in_pin; // Stale bit never looks held
    // Select must really stand high, or the next call merges into this frame
    if (!keep) #30;
  endtask : xfer
endmodule : tsp_host

// ==== test/tsp_spi_port_test.sv ====
module tsp_spi_port_test;
  timeunit 1ns;
  timeprecision 1ps;
  logic        clk, resetn, sclk, cs_n, serial_in_pin, serial_out_pin, serial_out_oe;
  logic        touch_data_irq_out, pen_touch_flag, data_avail, mirror_wr, mirror_ready;
  logic        cmd_valid, wr_valid;
  logic [1:0]  irq_sel;
  logic [3:0]  mirror_addr, wr_addr;
  logic [15:0] mirror_data, wr_data;
  logic [7:0]  cmd_byte;
  logic [23:0] q;
  logic        miso_line;
  int          n_errors, tests_run, n_cmd, n_wr, cyc;
  // ========
  // Released master-in line shows the inverse, so a read of an undriven bit shows up
  assign miso_line = serial_out_oe ? serial_out_pin : ~serial_out_pin;
  tsp_spi_port dut_u (
    .clk                (clk),
    .resetn             (resetn),
    .sclk               (sclk),
    .cs_n               (cs_n),
    .serial_in_pin      (serial_in_pin),
    .serial_out_pin     (serial_out_pin),
    .serial_out_oe      (serial_out_oe),
    .touch_data_irq_out (touch_data_irq_out),
    .irq_sel            (irq_sel),
    .pen_touch_flag     (pen_touch_flag),
    .data_avail         (data_avail),
    .mirror_wr          (mirror_wr),
    .mirror_addr        (mirror_addr),
    .mirror_data        (mirror_data),
    .mirror_ready       (mirror_ready),
    .cmd_valid          (cmd_valid),
    .cmd_byte           (cmd_byte),
    .wr_valid           (wr_valid),
    .wr_addr            (wr_addr),
    .wr_data            (wr_data)
  );
  tsp_host host_u (
    .sclk           (sclk),
    .cs_n           (cs_n),
    .serial_in_pin  (serial_in_pin),
    .serial_out_pin (miso_line)
  );
  // 125 MHz system clock
  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end
  // Pulse counts and hang guard, sampled off the launching edge
  always @(negedge clk) begin
    cyc++;
    if (cmd_valid === 1'b1) n_cmd++;
    if (wr_valid === 1'b1) n_wr++;
    if (cyc == 20000) begin
      n_errors++;
      print_verdict();
    end
  end
  task automatic check(input string what, input logic [23:0] exp, input logic [23:0] got);
    tests_run++;
    if (got !== exp) begin
      $display("mismatch %s expected %h seen %h", what, exp, got);
      n_errors++;
    end
  endtask : check
  task automatic print_verdict();
    if (n_errors == 0 && tests_run > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask : print_verdict
  task automatic t_reset();
    check("idle", 24'h3, {mirror_ready, touch_data_irq_out});
    host_u.xfer(24'h040000, 24, 1'b0, q);
    check("read0", 24'h0, q[15:0]);
  endtask : t_reset
  // Control byte then a write under one select
  task automatic t_ctrl_write();
    host_u.xfer(24'h0000a5, 8, 1'b1, q);
    host_u.xfer(24'h28c3a1, 24, 1'b0, q);
    repeat (8) @(negedge clk);
    check("cmd_byte", 24'ha5, cmd_byte);
    check("wr_addr", 24'h5, wr_addr);
    check("wr_data", 24'hc3a1, wr_data);
    check("pulses", 24'h11, {n_cmd[3:0], n_wr[3:0]});
  endtask : t_ctrl_write
  // Cut-short write and control byte must leave no trace
  task automatic t_abort();
    host_u.xfer(24'h028fff, 20, 1'b0, q);
    host_u.xfer(24'h00001f, 5, 1'b0, q);
    repeat (8) @(negedge clk);
    check("pulses", 24'h11, {n_cmd[3:0], n_wr[3:0]});
    check("wr_data", 24'hc3a1, wr_data);
  endtask : t_abort
  task automatic t_read();
    mirror_addr = 4'h9;
    mirror_data = 16'h5a3c;
    mirror_wr = 1'b1;
    @(negedge clk);
    mirror_wr = 1'b0;
    host_u.xfer(24'h4c0000, 24, 1'b0, q);
    check("read", 24'h5a3c, q[15:0]);
    @(negedge clk);
    check("oe", 24'h0, serial_out_oe);
  endtask : t_read
  // Every source selection against every flag pair
  task automatic t_irq();
    for (int s = 0; s < 16; s++) begin
      {irq_sel, pen_touch_flag, data_avail} = s[3:0];
      repeat (3) @(negedge clk);
      check("irq", !(s[3:2] == 0 && s[1] || s[3:2] == 1 && s[0] ||
        s[3:2] == 2 && s[1:0] != 0), touch_data_irq_out);
    end
  endtask : t_irq
  // Reset in mid-run clears outputs and readback words
  task automatic t_midreset();
    {irq_sel, pen_touch_flag, data_avail} = 4'h2;
    resetn = 1'b0;
    repeat (8) @(negedge clk);
    check("cmd_rst", 24'h0, cmd_byte);
    check("wr_rst", 24'h0, {wr_addr, wr_data});
    check("irq_rst", 24'h1, touch_data_irq_out);
    resetn = 1'b1;
    repeat (8) @(negedge clk);
    check("irq_pen", 24'h0, touch_data_irq_out);
    host_u.xfer(24'h4c0000, 24, 1'b0, q);
    check("read_rst", 24'h0, q[15:0]);
  endtask : t_midreset
  initial begin
    resetn = 1'b0;
    {irq_sel, pen_touch_flag, data_avail, mirror_wr} = 5'h00;
    mirror_addr = 4'h0;
    mirror_data = 16'h0000;
    repeat (8) @(negedge clk);
    resetn = 1'b1;
    repeat (8) @(negedge clk);
    t_reset();
    t_ctrl_write();
    t_abort();
    t_read();
    t_irq();
    t_midreset();
    print_verdict();
  end
endmodule : tsp_spi_port_test
bind tsp_spi_port tsp_spi_port_props props_u (
  .clk                (clk),
  .resetn             (resetn),
  .sclk               (sclk),
  .cs_n               (cs_n),
  .serial_out_pin     (serial_out_pin),
  .serial_out_oe      (serial_out_oe),
  .touch_data_irq_out (touch_data_irq_out),
  .irq_sel            (irq_sel),
  .pen_touch_flag     (pen_touch_flag),
  .mirror_ready       (mirror_ready),
  .cmd_valid          (cmd_valid),
  .cmd_byte           (cmd_byte),
  .wr_valid           (wr_valid),
  .wr_data            (wr_data)
);
